// >>> design/dct_delay.sv
// module: loadable countdown that pulses a given number of cycles after its load
`timescale 1ns/1ps
module dct_delay
  import dct_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       load,
  input  wire logic [7:0] count,
  output logic            fire,
  output logic            busy
);

  // ==========================================================================
  // counter
  // ==========================================================================
  logic [7:0] cnt_reg;  // cycles left
  logic       fire_reg; // one-cycle pulse
  logic [7:0] cnt_next; // next count

  // a fresh load overrides a countdown still in flight
  assign cnt_next = load ? count : ((cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00);

  // count down; fire when the last cycle has passed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= 8'h00;
      fire_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      fire_reg <= (cnt_reg == 8'h01) && !load;
    end
  end

  assign fire = fire_reg;
  assign busy = (cnt_reg != 8'h00);

endmodule : dct_delay

// >>> design/dct_pkg.sv
// package: register map, field layout, reset values and timing counts of the timing block
package dct_pkg;

  // ==========================================================================
  // register byte offsets
  // ==========================================================================
  localparam logic [7:0] DCT_ADDR_MODE0  = 8'h00; // burst mode and write recovery
  localparam logic [7:0] DCT_ADDR_MODE4  = 8'h04; // preamble selects
  localparam logic [7:0] DCT_ADDR_LAT    = 8'h08; // write and read latency
  localparam logic [7:0] DCT_ADDR_SPEED  = 8'h0C; // speed grade code
  localparam logic [7:0] DCT_ADDR_STATUS = 8'h10; // read-only live state

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int DCT_BM_LSB     = 0;  // mode0 burst mode [1:0]
  localparam int DCT_WR_LSB     = 4;  // mode0 write recovery [8:4]
  localparam int DCT_RDPRE_BIT  = 11; // mode4 read preamble select
  localparam int DCT_WRPRE_BIT  = 12; // mode4 write preamble select
  localparam int DCT_WL_LSB     = 0;  // lat write latency [5:0]
  localparam int DCT_RL_LSB     = 8;  // lat read latency [13:8]
  localparam int DCT_ST_BUSY    = 0;  // status: an operation in progress
  localparam int DCT_ST_LP      = 1;  // status: low-power state in effect
  localparam int DCT_ST_RDPRE2  = 2;  // status: two-cycle read preamble active
  localparam int DCT_ST_WRPRE2  = 3;  // status: two-cycle write preamble active
  localparam int DCT_ST_DQS     = 4;  // status: strobe driven

  // ==========================================================================
  // modes and reset values
  // ==========================================================================
  typedef enum logic [1:0] {
    DCT_BL8_FIXED = 2'h0,  // burst of eight set by mode register
    DCT_OTF       = 2'h1,  // burst chosen per command
    DCT_BC4_FIXED = 2'h2   // chop of four set by mode register
  } dct_burst_type;

  localparam logic [1:0] DCT_SPEED_LOW = 2'h0; // any grade below 2400
  localparam logic [4:0] DCT_WR_RST    = 5'h0A;
  localparam logic [5:0] DCT_WL_RST    = 6'h09;
  localparam logic [5:0] DCT_RL_RST    = 6'h0B;
  localparam logic [1:0] DCT_SPEED_RST = 2'h3;
  localparam logic [1:0] DCT_RESP_OK   = 2'h0;
  localparam logic [1:0] DCT_RESP_ERR  = 2'h2;

  // ==========================================================================
  // timing counts
  // ==========================================================================
  localparam logic [7:0] DCT_START_FULL = 8'h04; // internal write start after write latency
  localparam logic [7:0] DCT_START_CHOP = 8'h02; // same, chop fixed by mode register
  localparam logic [7:0] DCT_BURST_FULL = 8'h04; // clock cycles of a burst of eight
  localparam logic [7:0] DCT_BURST_CHOP = 8'h02; // clock cycles of a chop of four
  localparam int DCT_CLK_PS   = 5000;          // 200 MHz clock period
  localparam int DCT_OP_NS    = 40;            // row/refresh operation duration
  localparam int DCT_OP_CK    = (DCT_OP_NS * 1000 + DCT_CLK_PS - 1) / DCT_CLK_PS;
  localparam logic [7:0] DCT_OP_CYCLES = DCT_OP_CK[7:0];

  // commands taken from the controller in one cycle
  typedef struct packed {
    logic wr;       // write command
    logic wr_chop;  // on-the-fly chop for this write
    logic wr_ap;    // write with auto precharge
    logic rd;       // read command
    logic rd_chop;  // on-the-fly chop for this read
    logic bank_op;  // activate, precharge or refresh
    logic cke;      // clock enable level
  } dct_cmd_type;

endpackage : dct_pkg

// >>> design/dct_timing.sv
// module: device-side command timing with register access over AXI4-Lite
//
// Summary of operation
// - burst eight or otf chop: start WL+4
// - chop fixed by mode: start WL+2
// - recovery counted in cycles from mode register
// - low power waits for running operations
// - mode four bit eleven: read preamble
// - mode four bit twelve: write preamble
// - two-cycle read preamble releases strobe earlier
`timescale 1ns/1ps
module dct_timing
  import dct_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire dct_cmd_type cmd,
  output logic             wr_start,
  output logic             auto_pre_start,
  output logic             dqs_oe,
  output logic             low_power
);

  // ==========================================================================
  // configuration registers
  // ==========================================================================
  logic [1:0]  bm_reg;      // burst mode
  logic [4:0]  wrec_reg;    // write recovery in cycles
  logic        rdpre_reg;   // read preamble select
  logic        wrpre_reg;   // write preamble select
  logic [5:0]  wl_reg;      // write latency
  logic [5:0]  rl_reg;      // read latency
  logic [1:0]  speed_reg;   // speed grade code

  // ==========================================================================
  // bus slave state
  // ==========================================================================
  logic        aw_rdy_reg;  // write address taken pulse
  logic        bvalid_reg;  // write response pending
  logic [1:0]  bresp_reg;   // write response code
  logic        ar_rdy_reg;  // read address taken pulse
  logic        rvalid_reg;  // read data pending
  logic [31:0] rdata_reg;   // read data
  logic [1:0]  rresp_reg;   // read response code

  // ==========================================================================
  // decode
  // ==========================================================================
  wire wr_take  = s_axi_awvalid && s_axi_wvalid && !aw_rdy_reg && !bvalid_reg;
  wire rd_take  = s_axi_arvalid && !ar_rdy_reg && !rvalid_reg;
  wire sel_m0   = (s_axi_awaddr == DCT_ADDR_MODE0);
  wire sel_m4   = (s_axi_awaddr == DCT_ADDR_MODE4);
  wire sel_lat  = (s_axi_awaddr == DCT_ADDR_LAT);
  wire sel_spd  = (s_axi_awaddr == DCT_ADDR_SPEED);
  wire wr_hit   = sel_m0 || sel_m4 || sel_lat || sel_spd;
  wire rd_hit   = (s_axi_araddr == DCT_ADDR_MODE0) || (s_axi_araddr == DCT_ADDR_MODE4) ||
                  (s_axi_araddr == DCT_ADDR_LAT) || (s_axi_araddr == DCT_ADDR_SPEED) ||
                  (s_axi_araddr == DCT_ADDR_STATUS);
  wire [31:0] wd = s_axi_wdata;
  wire [3:0]  ws = s_axi_wstrb;

  // ==========================================================================
  // effective preamble lengths
  // ==========================================================================
  // two-cycle read preamble only above 2133
  wire rdpre2 = rdpre_reg && (speed_reg != DCT_SPEED_LOW);
  wire wrpre2 = wrpre_reg && (speed_reg != DCT_SPEED_LOW);

  // ==========================================================================
  // operation tracking
  // ==========================================================================
  logic       ap_pend_reg;  // auto precharge waiting on internal write
  logic       chop_reg;     // chop length of the write in flight
  logic [7:0] op_cnt_reg;   // row or refresh operation still running
  logic [7:0] dqs_cnt_reg;  // strobe drive cycles left
  logic       rchop_reg;    // chop length of the read in flight
  logic       wr_fire;      // internal write start
  logic       ap_fire;      // precharge start
  logic       dqs_fire;     // strobe release
  logic       wr_busy;      // write timer running
  logic       ap_busy;      // precharge timer running
  logic       dqs_busy;     // strobe timer running

  // full burst or otf chop starts four after
  wire        fixed_chop = (bm_reg == DCT_BC4_FIXED);
  wire [7:0]  wr_delay   = {2'h0, wl_reg} + (fixed_chop ? DCT_START_CHOP : DCT_START_FULL);
  wire        w_chop     = fixed_chop || ((bm_reg == DCT_OTF) && cmd.wr_chop);
  // recovery counted from mode zero cycles
  wire [7:0]  ap_delay   = {3'h0, wrec_reg} + (chop_reg ? DCT_BURST_CHOP : DCT_BURST_FULL);
  // two-cycle read preamble opens strobe one earlier
  wire [7:0]  pre_ck     = rdpre2 ? 8'h02 : 8'h01;
  wire [7:0]  rl_ext     = {2'h0, rl_reg};
  wire [7:0]  dqs_delay  = (rl_ext > pre_ck) ? rl_ext - pre_ck : 8'h01;
  wire        r_chop     = fixed_chop || ((bm_reg == DCT_OTF) && cmd.rd_chop);
  wire [7:0]  dqs_len    = pre_ck + (rchop_reg ? DCT_BURST_CHOP : DCT_BURST_FULL);
  // any operation in progress holds off low power
  wire        busy_any   = wr_busy || ap_busy || ap_pend_reg || dqs_busy ||
                           (op_cnt_reg != 8'h00) || (dqs_cnt_reg != 8'h00);

  // write start timer
  dct_delay u_wr_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (cmd.wr),
    .count   (wr_delay),
    .fire    (wr_fire),
    .busy    (wr_busy)
  );

  // precharge timer, armed at the internal write start
  dct_delay u_ap_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (wr_fire && ap_pend_reg),
    .count   (ap_delay),
    .fire    (ap_fire),
    .busy    (ap_busy)
  );

  // strobe release timer
  dct_delay u_dqs_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (cmd.rd),
    .count   (dqs_delay),
    .fire    (dqs_fire),
    .busy    (dqs_busy)
  );

  // ==========================================================================
  // register writes and write response
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bm_reg     <= DCT_BL8_FIXED;
      wrec_reg   <= DCT_WR_RST;
      rdpre_reg  <= 1'b0;
      wrpre_reg  <= 1'b0;
      wl_reg     <= DCT_WL_RST;
      rl_reg     <= DCT_RL_RST;
      speed_reg  <= DCT_SPEED_RST;
      aw_rdy_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= DCT_RESP_OK;
    end else begin
      aw_rdy_reg <= wr_take;
      if (wr_take) begin
        // mode zero low byte holds burst mode and recovery [7:4]; byte one holds recovery bit 8
        if (sel_m0 && ws[0]) bm_reg <= wd[DCT_BM_LSB +: 2];
        if (sel_m0 && ws[1]) wrec_reg <= {wd[8], wd[7:DCT_WR_LSB]};
        if (sel_m0 && !ws[1] && ws[0]) wrec_reg <= {wrec_reg[4], wd[7:DCT_WR_LSB]};
        if (sel_m4 && ws[1]) rdpre_reg <= wd[DCT_RDPRE_BIT];
        if (sel_m4 && ws[1]) wrpre_reg <= wd[DCT_WRPRE_BIT];
        if (sel_lat && ws[0]) wl_reg <= wd[DCT_WL_LSB +: 6];
        if (sel_lat && ws[1]) rl_reg <= wd[DCT_RL_LSB +: 6];
        if (sel_spd && ws[0]) speed_reg <= wd[1:0];
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? DCT_RESP_OK : DCT_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // register reads
  // ==========================================================================
  wire [31:0] status_word = {27'h0, (dqs_cnt_reg != 8'h00), wrpre2, rdpre2, low_power,
                             busy_any};
  wire [31:0] rd_mux =
    (s_axi_araddr == DCT_ADDR_MODE0) ? {23'h0, wrec_reg, 2'h0, bm_reg} :
    (s_axi_araddr == DCT_ADDR_MODE4) ? {19'h0, wrpre_reg, rdpre_reg, 11'h0} :
    (s_axi_araddr == DCT_ADDR_LAT)   ? {18'h0, rl_reg, 2'h0, wl_reg} :
    (s_axi_araddr == DCT_ADDR_SPEED) ? {30'h0, speed_reg} :
    (s_axi_araddr == DCT_ADDR_STATUS) ? status_word : 32'h0;

  // read channel: one read at a time, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= DCT_RESP_OK;
    end else begin
      ar_rdy_reg <= rd_take;
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_hit ? DCT_RESP_OK : DCT_RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // operation state
  // ==========================================================================
  logic lp_reg;     // low-power state in effect
  logic dqs_oe_reg; // strobe drive, registered for the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ap_pend_reg <= 1'b0;
      dqs_oe_reg  <= 1'b0;
      chop_reg    <= 1'b0;
      rchop_reg   <= 1'b0;
      op_cnt_reg  <= 8'h00;
      dqs_cnt_reg <= 8'h00;
      lp_reg      <= 1'b0;
    end else begin
      // a later write replaces the pending flags
      if (cmd.wr) begin
        ap_pend_reg <= cmd.wr_ap;
        chop_reg    <= w_chop;
      end else if (wr_fire) begin
        ap_pend_reg <= 1'b0;
      end
      if (cmd.rd) rchop_reg <= r_chop;
      if (cmd.bank_op) op_cnt_reg <= DCT_OP_CYCLES;
      else if (op_cnt_reg != 8'h00) op_cnt_reg <= op_cnt_reg - 8'h01;
      // strobe stays driven for preamble plus burst
      if (dqs_fire) dqs_cnt_reg <= dqs_len;
      else if (dqs_cnt_reg != 8'h00) dqs_cnt_reg <= dqs_cnt_reg - 8'h01;
      // same level the counter will show, so the pin comes from a flop
      dqs_oe_reg <= dqs_fire || (dqs_cnt_reg > 8'h01);
      // enter low power only when idle; a command this cycle counts as busy
      lp_reg <= !cmd.cke && !busy_any && !cmd.wr && !cmd.rd && !cmd.bank_op;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready  = aw_rdy_reg;
  assign s_axi_wready   = aw_rdy_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = ar_rdy_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign wr_start       = wr_fire;
  assign auto_pre_start = ap_fire;
  assign dqs_oe         = dqs_oe_reg;
  assign low_power      = lp_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_four_after_a: assert property (
    (cmd.wr && !fixed_chop && wl_reg == 6'h09 && !cmd.rd) ##1 !cmd.wr [*8] ##1 !cmd.wr [*5]
      |=> wr_start)
    else $error("internal write not at write latency plus four");
  wr_two_after_a: assert property (
    (cmd.wr && fixed_chop && wl_reg == 6'h09) ##1 !cmd.wr [*8] ##1 !cmd.wr [*3] |=> wr_start)
    else $error("chop-fixed internal write not at latency plus two");
  wr_not_early_a: assert property (
    cmd.wr |=> !wr_start)
    else $error("internal write started early");
  ap_recovery_a: assert property (
    (wr_start && ap_pend_reg && !chop_reg && wrec_reg == 5'h0A && !cmd.wr) |=>
      (!auto_pre_start && !cmd.wr) [*7] ##1
      (!auto_pre_start && !cmd.wr) [*7] ##1 auto_pre_start)
    else $error("precharge not at burst plus recovery cycles");
  lp_idle_a: assert property (
    low_power |-> $past(!busy_any) && $past(!cmd.cke) && $past(!cmd.bank_op))
    else $error("low power entered while busy");
  lp_hold_a: assert property (
    cmd.bank_op |=> !low_power [*2])
    else $error("low power during bank operation");
  rdpre_gate_a: assert property (
    (speed_reg == DCT_SPEED_LOW) |-> !rdpre2)
    else $error("two-cycle read preamble at low grade");
  wrpre_gate_a: assert property (
    (speed_reg == DCT_SPEED_LOW) |-> !wrpre2)
    else $error("two-cycle write preamble at low grade");
  dqs_early_a: assert property (
    (cmd.rd && rdpre2 && rl_reg == 6'h0B) ##1 !cmd.rd [*8] ##1 !cmd.rd |=> ##1 $rose(dqs_oe))
    else $error("strobe not released at read latency minus two");

  wr_cov_c:  cover property (cmd.wr && cmd.wr_ap ##[1:40] auto_pre_start);
  rd_cov_c:  cover property (cmd.rd && rdpre2 ##[1:70] dqs_oe);
  lp_cov_c:  cover property (cmd.bank_op ##1 !cmd.cke [*8] ##2 low_power);
  bus_cov_c: cover property (s_axi_bvalid && s_axi_bresp == DCT_RESP_ERR);

endmodule : dct_timing

// >>> verif/dct_ctrl_model.sv
// partner model: controller side that issues commands to the timing block
`timescale 1ns/1ps
module dct_ctrl_model
  import dct_pkg::*;
(
  input  wire logic aclk,
  output dct_cmd_type cmd
);
  logic dll_locked = 1'b1;    // delay loop lock as seen by the controller
  int   cyc_now    = 0;       // cycles since start
  int   last_issue = -16;     // cycle of the latest command
  localparam int CMD_GAP = 5; // least spacing between commands, in cycles
  // no check, mask, geardown or register-read commands
  // one device, one fixed rate, no geardown entry

  always @(posedge aclk) begin
    cyc_now <= cyc_now + 1;
  end

  function automatic int ns_to_ck(input int ns);
    return (ns * 1000 + DCT_CLK_PS - 1) / DCT_CLK_PS;
  endfunction : ns_to_ck

  // idle with clock enable high so the device starts awake
  initial begin
    cmd = '0;
    cmd.cke = 1'b1;
  end

  // =========
  // one command pulse, clock enable level held afterwards
  // =========
  task issue(input dct_cmd_type c);
    dct_cmd_type rest;
    rest = '0;
    rest.cke = c.cke;
    if (!dll_locked) begin
      c.rd = 1'b0;
    end
    // hold off until the spacing has passed
    while (cyc_now - last_issue < CMD_GAP) begin
      @(posedge aclk);
    end
    @(posedge aclk);
    cmd <= c;
    last_issue = cyc_now;
    @(posedge aclk);
    cmd <= rest;
  endtask : issue
endmodule : dct_ctrl_model

// >>> verif/ddr4_command_timing_rules_bench.sv
// testbench: register access, write start, strobe and low-power timing
`timescale 1ns/1ps
module ddr4_command_timing_rules_bench
  import dct_pkg::*;
();
  logic        aclk = 1'b0;     // 200 MHz clock
  logic        aresetn = 1'b0;  // held low at start
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  dct_cmd_type cmd;             // driven by the partner model
  logic        wr_start, auto_pre_start, dqs_oe, low_power;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;         // timeout counter
  int          n, p, bl;        // measured count, preamble, burst
  logic [1:0]  mode, sp;        // burst mode, speed grade
  logic [4:0]  wr;              // write recovery cycles
  logic [5:0]  wl, rl;          // latencies
  logic        chop, pre;       // on-the-fly chop, two-cycle preamble
  dct_cmd_type c;

  dct_timing i_dct_timing (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmd(cmd), .wr_start(wr_start),
    .auto_pre_start(auto_pre_start), .dqs_oe(dqs_oe), .low_power(low_power));

  dct_ctrl_model i_dct_ctrl_model (.aclk(aclk), .cmd(cmd));

  // =========
  // clock and hang guard
  // =========
  always #2.5 aclk = ~aclk;

  // a stuck handshake ends the run instead of hanging it
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // =========
  // compare, verdict and expectation helpers
  // =========
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      err_count++;
    end
  endtask : check

  task give_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // chop fixed by mode starts two cycles sooner
  function automatic int exp_start(input logic [1:0] m, input logic [5:0] w);
    return int'(w) + ((m == DCT_BC4_FIXED) ? 2 : 4);
  endfunction : exp_start

  function automatic int burst(input logic [1:0] m, input logic ch);
    return (m == DCT_BC4_FIXED || ch) ? 2 : 4;
  endfunction : burst

  function automatic logic sig(input int k);
    case (k)
      0: return wr_start;
      1: return auto_pre_start;
      2: return dqs_oe;
      default: return low_power;
    endcase
  endfunction : sig

  // edges until the chosen output reaches a level, settled after each edge
  task edges_until(input int k, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      #1;
      cnt++;
    end while (sig(k) !== lvl && cnt < 400);
  endtask : edges_until

  // =========
  // register bus master
  // =========
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : axi_write

  task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", ed, s_axi_rdata);
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : axi_read

  // =========
  // main sequence
  // =========
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(56772));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped read and read-only write
    axi_read(DCT_ADDR_MODE0, {23'h0, DCT_WR_RST, 4'h0}, DCT_RESP_OK);
    axi_read(DCT_ADDR_LAT, {18'h0, DCT_RL_RST, 2'h0, DCT_WL_RST}, DCT_RESP_OK);
    axi_read(DCT_ADDR_SPEED, {30'h0, DCT_SPEED_RST}, DCT_RESP_OK);
    axi_read(DCT_ADDR_MODE4, 32'h0, DCT_RESP_OK);
    axi_read(8'h14, 32'h0, DCT_RESP_ERR);
    axi_write(DCT_ADDR_STATUS, 32'h0, DCT_RESP_ERR);
    // two-cycle preambles take effect only at the faster grades
    for (int s = 0; s < 4; s++) begin
      axi_write(DCT_ADDR_SPEED, 32'(s), DCT_RESP_OK);
      axi_write(DCT_ADDR_MODE4, 32'h1800, DCT_RESP_OK);
      axi_read(DCT_ADDR_STATUS, (s != 0) ? 32'hC : 32'h0, DCT_RESP_OK);
    end
    // random latencies through every burst mode
    for (int i = 0; i < 12; i++) begin
      mode = 2'(i % 3);
      // first pass through each mode uses the reset latencies as corner cases
      wl = (i < 3) ? DCT_WL_RST : 6'(1 + $urandom % 20);
      rl = (i < 3) ? DCT_RL_RST : 6'(3 + $urandom % 18);
      wr = (i < 3) ? DCT_WR_RST : 5'(i_dct_ctrl_model.ns_to_ck(1 + $urandom % 120));
      chop = (mode == DCT_OTF) ? 1'($urandom % 2) : 1'b0;
      pre = (i < 3) ? 1'b1 : 1'($urandom % 2);
      sp = (i < 3) ? DCT_SPEED_RST : 2'($urandom % 4);
      axi_write(DCT_ADDR_MODE0, {23'h0, wr, 2'h0, mode}, DCT_RESP_OK);
      axi_write(DCT_ADDR_LAT, {18'h0, rl, 2'h0, wl}, DCT_RESP_OK);
      axi_write(DCT_ADDR_SPEED, {30'h0, sp}, DCT_RESP_OK);
      axi_write(DCT_ADDR_MODE4, {19'h0, pre, pre, 11'h0}, DCT_RESP_OK);
      bl = burst(mode, chop);
      p = (pre && sp != DCT_SPEED_LOW) ? 2 : 1;
      c = '0;
      c.cke = 1'b1;
      c.wr = 1'b1;
      c.wr_ap = 1'b1;
      c.wr_chop = chop;
      i_dct_ctrl_model.issue(c);
      edges_until(0, 1'b1, n);
      check("write_start", 32'(exp_start(mode, wl)), 32'(n));
      edges_until(1, 1'b1, n);
      check("auto_precharge", 32'(bl + int'(wr) + 1), 32'(n));
      c = '0;
      c.cke = 1'b1;
      c.rd = 1'b1;
      c.rd_chop = chop;
      i_dct_ctrl_model.issue(c);
      edges_until(2, 1'b1, n);
      check("strobe_rise", 32'(int'(rl) - p + 1), 32'(n));
      edges_until(2, 1'b0, n);
      check("strobe_width", 32'(p + bl), 32'(n));
    end
    // low power waits for the bank operation to finish
    c = '0;
    c.bank_op = 1'b1;
    i_dct_ctrl_model.issue(c);
    edges_until(3, 1'b1, n);
    check("lp_wait", 32'h1, {31'h0, n > 7 && n < 12});
    c = '0;
    c.cke = 1'b1;
    i_dct_ctrl_model.issue(c);
    edges_until(3, 1'b0, n);
    check("lp_exit", 32'h1, {31'h0, n < 4});
    give_verdict();
  end
endmodule : ddr4_command_timing_rules_bench
